// File: core/cmd_ctrl_pkg.sv
package cmd_ctrl_pkg;
    // register offsets (byte addresses)
    localparam logic [11:0] CMD_OFFSET    = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] TIMER_OFFSET  = 12'h008;
    localparam logic [11:0] TALLY_OFFSET  = 12'h00C;

    // command register field positions
    localparam int SOFT_RESET_BIT = 7;
    localparam int RESERVED_BIT   = 6;
    localparam int TIMER_RUN_BIT  = 5;
    localparam int TIMER_HALT_BIT = 4;

    // status register field positions
    localparam int STAT_OPER_BIT  = 0;
    localparam int STAT_COUNT_BIT = 1;

    // values after reset, and the counter step COUNT_ONE
    localparam logic        SOFT_RESET_RST = 1'b1;
    localparam logic        TIMER_RUN_RST  = 1'b0;
    localparam logic        TIMER_HALT_RST = 1'b0;
    localparam logic [31:0] COUNT_RST      = 32'h0000_0000;
    localparam logic [31:0] COUNT_ONE      = 32'h0000_0001;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

    // reset release synchroniser depth
    localparam int RESET_SYNC_STAGES = 2;
endpackage : cmd_ctrl_pkg

// File: core/cmd_ctrl.sv
// Behaviour
// - soft reset bit 7 resets internal state machines
// - soft reset: CRC off, tallies frozen not cleared
// - hardware reset sets soft reset bit
// - non-operational until soft reset written 0
// - writing timer_run 1 starts or resumes timer
// - timer_run cleared whenever timer_halt set
// - setting timer_run clears timer_halt
// - writing timer_halt 1 stops timer, clears run
//
// Added by the designer: the address map and the APB register port.
module cmd_ctrl (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // device side
    input  wire logic        tally_event_i,
    output logic             fsm_reset_o,
    output logic             crc_enable_o,
    output logic             tally_enable_o,
    output logic             timer_enable_o,
    output logic      [31:0] timer_count_o
);

    typedef struct packed {
        logic        soft_reset;
        logic        timer_run;
        logic        timer_halt;
        logic [31:0] timer_cnt;
        logic [31:0] tally_cnt;
        logic [31:0] rdata;
        logic        err;
    } state_s;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_SETUP,
        BUS_ACCESS
    } bus_phase_e;

    logic [cmd_ctrl_pkg::RESET_SYNC_STAGES-1:0] rst_sync_reg;
    logic                                        rst_n;
    state_s                                      state_reg;
    state_s                                      state_next;
    bus_phase_e                                  phase;
    logic                                        setup;
    logic                                        wr_access;
    logic                                        mapped;
    logic                                        cmd_wr;
    logic                                        wr_run;
    logic                                        wr_halt;
    logic [31:0]                                 cmd_view;
    logic [31:0]                                 status_view;

    // release of the async reset is synchronised; assertion is immediate
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= '0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[cmd_ctrl_pkg::RESET_SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[cmd_ctrl_pkg::RESET_SYNC_STAGES-1];

    assign setup     = psel_i && !penable_i;
    assign wr_access = psel_i && penable_i && pwrite_i;
    assign cmd_wr    = wr_access && paddr_i == cmd_ctrl_pkg::CMD_OFFSET;
    assign wr_run    = cmd_wr && pwdata_i[cmd_ctrl_pkg::TIMER_RUN_BIT];
    assign wr_halt   = cmd_wr && pwdata_i[cmd_ctrl_pkg::TIMER_HALT_BIT];

    always_comb begin
        if (!psel_i) begin
            phase = BUS_IDLE;
        end else if (!penable_i) begin
            phase = BUS_SETUP;
        end else begin
            phase = BUS_ACCESS;
        end
    end

    always_comb begin
        case (paddr_i)
            cmd_ctrl_pkg::CMD_OFFSET,
            cmd_ctrl_pkg::STATUS_OFFSET,
            cmd_ctrl_pkg::TIMER_OFFSET,
            cmd_ctrl_pkg::TALLY_OFFSET: mapped = 1'b1;
            default:                    mapped = 1'b0;
        endcase
    end

    // reserved bit always reads zero
    always_comb begin
        cmd_view                               = cmd_ctrl_pkg::READ_ZERO;
        cmd_view[cmd_ctrl_pkg::SOFT_RESET_BIT] = state_reg.soft_reset;
        cmd_view[cmd_ctrl_pkg::TIMER_RUN_BIT]  = state_reg.timer_run;
        cmd_view[cmd_ctrl_pkg::TIMER_HALT_BIT] = state_reg.timer_halt;
        status_view                               = cmd_ctrl_pkg::READ_ZERO;
        status_view[cmd_ctrl_pkg::STAT_OPER_BIT]  = !state_reg.soft_reset;
        status_view[cmd_ctrl_pkg::STAT_COUNT_BIT] = timer_enable_o;
    end

    always_comb begin
        state_next = state_reg;

        // read data is captured in setup so that prdata comes from a flop
        if (setup) begin
            state_next.err = !mapped;
            case (paddr_i)
                cmd_ctrl_pkg::CMD_OFFSET:    state_next.rdata = cmd_view;
                cmd_ctrl_pkg::STATUS_OFFSET: state_next.rdata = status_view;
                cmd_ctrl_pkg::TIMER_OFFSET:  state_next.rdata = state_reg.timer_cnt;
                cmd_ctrl_pkg::TALLY_OFFSET:  state_next.rdata = state_reg.tally_cnt;
                default:                     state_next.rdata = cmd_ctrl_pkg::READ_ZERO;
            endcase
        end

        // timer counts only while running and the device is operational
        if (timer_enable_o) begin
            state_next.timer_cnt = state_reg.timer_cnt + cmd_ctrl_pkg::COUNT_ONE;
        end
        // tallies hold their value during soft reset
        if (tally_event_i && !state_reg.soft_reset) begin
            state_next.tally_cnt = state_reg.tally_cnt + cmd_ctrl_pkg::COUNT_ONE;
        end

        if (cmd_wr) begin
            state_next.soft_reset = pwdata_i[cmd_ctrl_pkg::SOFT_RESET_BIT];
            // bit 6 is ignored on write
            if (pwdata_i[cmd_ctrl_pkg::TIMER_RUN_BIT]) begin
                state_next.timer_run  = 1'b1;
                state_next.timer_halt = 1'b0;
            end
            // halt wins when both are written together: stopping is the safe side
            if (pwdata_i[cmd_ctrl_pkg::TIMER_HALT_BIT]) begin
                state_next.timer_halt = 1'b1;
                state_next.timer_run  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.soft_reset <= cmd_ctrl_pkg::SOFT_RESET_RST;
            state_reg.timer_run  <= cmd_ctrl_pkg::TIMER_RUN_RST;
            state_reg.timer_halt <= cmd_ctrl_pkg::TIMER_HALT_RST;
            state_reg.timer_cnt  <= cmd_ctrl_pkg::COUNT_RST;
            state_reg.tally_cnt  <= cmd_ctrl_pkg::COUNT_RST;
            state_reg.rdata      <= cmd_ctrl_pkg::READ_ZERO;
            state_reg.err        <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // no wait states: setup captures, access answers at once
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i && penable_i && state_reg.err;
    assign prdata_o       = state_reg.rdata;
    assign fsm_reset_o    = state_reg.soft_reset;
    assign crc_enable_o   = !state_reg.soft_reset;
    assign tally_enable_o = !state_reg.soft_reset;
    assign timer_enable_o = state_reg.timer_run && !state_reg.soft_reset;
    assign timer_count_o  = state_reg.timer_cnt;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    run_halt_excl_a: assert property (!(state_reg.timer_run && state_reg.timer_halt))
        else $error("run and halt both set");

    halt_clears_run_a: assert property ($rose(state_reg.timer_halt) |-> !state_reg.timer_run)
        else $error("run still set after halt");

    halt_write_a: assert property (wr_halt
        |=> state_reg.timer_halt && !timer_enable_o ##1 $stable(timer_count_o))
        else $error("halt write did not stop timer");

    run_write_a: assert property (wr_run
        && !pwdata_i[cmd_ctrl_pkg::TIMER_HALT_BIT] && !pwdata_i[cmd_ctrl_pkg::SOFT_RESET_BIT]
        |=> timer_enable_o ##1 timer_count_o == $past(timer_count_o) + cmd_ctrl_pkg::COUNT_ONE)
        else $error("run write did not start timer");

    soft_reset_set_a: assert property (cmd_wr && pwdata_i[cmd_ctrl_pkg::SOFT_RESET_BIT]
        |=> fsm_reset_o && !crc_enable_o)
        else $error("soft reset write not applied");

    tally_freeze_a: assert property (fsm_reset_o |=> $stable(state_reg.tally_cnt))
        else $error("tally moved during soft reset");

    oper_needs_clear_a: assert property ($fell(fsm_reset_o) |-> $past(cmd_wr)
        && !$past(pwdata_i[cmd_ctrl_pkg::SOFT_RESET_BIT]))
        else $error("left soft reset without a write");

    timer_hold_a: assert property (!timer_enable_o |=> $stable(timer_count_o))
        else $error("timer moved while disabled");

    soft_reset_hold_a: assert property (fsm_reset_o && !cmd_wr |=> fsm_reset_o)
        else $error("soft reset cleared without a write");

    clear_enables_a: assert property (cmd_wr && !pwdata_i[cmd_ctrl_pkg::SOFT_RESET_BIT]
        |=> crc_enable_o && tally_enable_o && !fsm_reset_o)
        else $error("clearing soft reset did not enable");

    tally_count_a: assert property (tally_event_i && tally_enable_o
        |=> state_reg.tally_cnt == $past(state_reg.tally_cnt) + cmd_ctrl_pkg::COUNT_ONE)
        else $error("tally event not counted");

    run_clears_halt_a: assert property (wr_run && !pwdata_i[cmd_ctrl_pkg::TIMER_HALT_BIT]
        |=> !state_reg.timer_halt && state_reg.timer_run)
        else $error("run write left halt set");

    halt_drops_run_a: assert property (wr_halt |=> !state_reg.timer_run)
        else $error("halt write left run set");

    zero_write_keeps_a: assert property (cmd_wr && !wr_run && !wr_halt
        |=> $stable(state_reg.timer_run) && $stable(state_reg.timer_halt))
        else $error("zero write changed timer bits");

    timer_run_count_a: assert property (timer_enable_o
        |=> timer_count_o == $past(timer_count_o) + cmd_ctrl_pkg::COUNT_ONE)
        else $error("enabled timer did not count");

    halt_stops_a: assert property (state_reg.timer_halt |-> !timer_enable_o)
        else $error("timer enabled while halted");

    read_capture_a: assert property (setup && paddr_i == cmd_ctrl_pkg::CMD_OFFSET
        |=> prdata_o[cmd_ctrl_pkg::SOFT_RESET_BIT] == $past(state_reg.soft_reset))
        else $error("command read data not captured");

    status_read_a: assert property (setup && paddr_i == cmd_ctrl_pkg::STATUS_OFFSET
        |=> prdata_o[cmd_ctrl_pkg::STAT_OPER_BIT] == !$past(fsm_reset_o))
        else $error("status operational bit wrong");

    unmapped_err_a: assert property (setup && !mapped
        |=> state_reg.err && prdata_o == cmd_ctrl_pkg::READ_ZERO)
        else $error("unmapped access not flagged");

    bad_write_ignored_a: assert property (wr_access && !mapped
        |=> $stable(state_reg.soft_reset) && $stable(state_reg.timer_run))
        else $error("unmapped write changed state");

    count_in_soft_a: assert property (fsm_reset_o |=> $stable(timer_count_o))
        else $error("timer moved during soft reset");

    run_held_soft_a: assert property (fsm_reset_o && !cmd_wr |=> $stable(state_reg.timer_run))
        else $error("run bit moved during soft reset");

    // snapshot at soft reset entry: catches slow drift that a one-cycle check misses
    logic [31:0] tally_snap_reg;
    logic        frozen_reg;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tally_snap_reg <= cmd_ctrl_pkg::COUNT_RST;
            frozen_reg     <= 1'b0;
        end else begin
            if (!frozen_reg) begin
                tally_snap_reg <= state_reg.tally_cnt;
            end
            frozen_reg <= fsm_reset_o;
        end
    end

    tally_snap_a: assert property (frozen_reg && fsm_reset_o
        |-> state_reg.tally_cnt == tally_snap_reg)
        else $error("tally drifted during soft reset");

    // hardware reset release must leave soft reset set
    always_ff @(posedge clk_i) begin
        if (rst_sync_reg == 2'b01) begin
            hw_reset_a: assert (state_reg.soft_reset)
                else $error("soft reset not set after hw reset");
        end
    end

    start_cover_c:  cover property (cmd_wr && pwdata_i[cmd_ctrl_pkg::TIMER_RUN_BIT]
        ##[1:20] timer_enable_o);
    halt_cover_c:   cover property (timer_enable_o ##1 $rose(state_reg.timer_halt));
    resume_cover_c: cover property ($fell(state_reg.timer_halt) ##[1:20] timer_enable_o);
    oper_cover_c:   cover property ($fell(fsm_reset_o));
    err_cover_c:    cover property (pslverr_o);

    logic unused_phase;
    assign unused_phase = (phase == BUS_IDLE);

endmodule : cmd_ctrl

// File: verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i;
    logic        reset_n_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        tally_event_i;
    logic        fsm_reset_o;
    logic        crc_enable_o;
    logic        tally_enable_o;
    logic        timer_enable_o;
    logic [31:0] timer_count_o;
    logic [31:0] rd;
    logic [31:0] t1;
    logic        err;
    int          err_total;
    int          checks_done;
    int          cyc;

    cmd_ctrl u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .tally_event_i(tally_event_i), .fsm_reset_o(fsm_reset_o),
        .crc_enable_o(crc_enable_o), .tally_enable_o(tally_enable_o),
        .timer_enable_o(timer_enable_o), .timer_count_o(timer_count_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : xfer

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic tally(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tally_event_i <= 1'b1;
            @(posedge clk_i);
            tally_event_i <= 1'b0;
        end
    endtask : tally

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // generous ceiling: the sequence needs under a hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        {psel_i, penable_i, pwrite_i, tally_event_i} = 4'h0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        {err_total, checks_done, cyc} = '0;
        reset_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        xfer(1'b0, cmd_ctrl_pkg::CMD_OFFSET, 32'h0);
        chk(rd, 32'h0000_0080);
        chk({fsm_reset_o, crc_enable_o, tally_enable_o}, 32'h4);
        tally(2);
        xfer(1'b0, cmd_ctrl_pkg::TALLY_OFFSET, 32'h0);
        chk(rd, 32'h0);
        $display("test reset_state done");
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_0000);
        settle();
        chk({fsm_reset_o, crc_enable_o, tally_enable_o}, 32'h3);
        xfer(1'b0, cmd_ctrl_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, 32'h1);
        tally(3);
        xfer(1'b0, cmd_ctrl_pkg::TALLY_OFFSET, 32'h0);
        chk(rd, 32'h3);
        $display("test operational done");
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_0020);
        settle();
        chk(timer_enable_o, 32'h1);
        xfer(1'b0, cmd_ctrl_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, 32'h3);
        xfer(1'b0, cmd_ctrl_pkg::TIMER_OFFSET, 32'h0);
        chk(rd != 32'h0, 32'h1);
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_0010);
        xfer(1'b0, cmd_ctrl_pkg::CMD_OFFSET, 32'h0);
        chk(rd, 32'h0000_0010);
        settle();
        t1 = timer_count_o;
        chk(t1 > 0, 32'h1);
        settle();
        chk(timer_count_o, t1);
        // resume from halt, reserved bit kept at zero
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_0020);
        xfer(1'b0, cmd_ctrl_pkg::CMD_OFFSET, 32'h0);
        chk(rd, 32'h0000_0020);
        settle();
        chk(timer_count_o > t1, 32'h1);
        // both timer bits in one write: halt wins
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_0030);
        xfer(1'b0, cmd_ctrl_pkg::CMD_OFFSET, 32'h0);
        chk(rd, 32'h0000_0010);
        $display("test timer done");
        xfer(1'b1, cmd_ctrl_pkg::CMD_OFFSET, 32'h0000_00A0);
        settle();
        t1 = timer_count_o;
        chk({fsm_reset_o, crc_enable_o, timer_enable_o}, 32'h4);
        tally(2);
        xfer(1'b0, cmd_ctrl_pkg::TALLY_OFFSET, 32'h0);
        chk(rd, 32'h3);
        chk(timer_count_o, t1);
        xfer(1'b0, 12'h010, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        $display("test soft_reset_again done");
        finish_test();
    end
endmodule : tb_top
